// ===== design/reset_cause_and_sleep_power_status.sv
`timescale 1ns/1ps
// Functional notes
// [RULE1] watchdog expiry event sets the watchdog flag, bit 4, sticky until cleared
// [RULE2] leaving sleep sets the wake-from-sleep flag, bit 3
// [RULE3] leaving idle sets the wake-from-idle flag, bit 2
// [RULE4] brown-out reset sets the undervoltage flag, bit 1
// [RULE5] power-on reset sets the power-up flag, bit 0
// [RULE6] brown-out and power-on flags hold until software clears them
// [RULE7] keep-alive 1 keeps regulator active in sleep; 0 puts it in standby
// [RULE8] power control bits 31 to 1 always read zero
module reset_cause_and_sleep_power_status
   import rst_cause_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // event sources, asynchronous to core_clk
   input  wire logic        watchdog_expiry_evt,
   input  wire logic        sleep_exit_evt,
   input  wire logic        idle_exit_evt,
   input  wire logic        brownout_evt,
   input  wire logic        poweron_evt,
   input  wire logic        sleep_active,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // regulator control
   output logic             regulator_standby,
   output logic             regulator_keepalive_select
);

   ////////////////////////////////////////////////////////////////////////
   // event synchronisers and rising-edge detect
   logic [CAUSE_WIDTH-1:0] evt_raw;
   logic [CAUSE_WIDTH-1:0] sync1_q;
   logic [CAUSE_WIDTH-1:0] sync2_q;
   logic [CAUSE_WIDTH-1:0] sync3_q;
   logic [CAUSE_WIDTH-1:0] evt_pulse;
   logic                   sleep_s1_q;
   logic                   sleep_s2_q;

   assign evt_raw[WATCHDOG_BIT]     = watchdog_expiry_evt;
   assign evt_raw[WAKE_SLEEP_BIT]   = sleep_exit_evt;
   assign evt_raw[WAKE_IDLE_BIT]    = idle_exit_evt;
   assign evt_raw[UNDERVOLTAGE_BIT] = brownout_evt;
   assign evt_raw[POWERUP_BIT]      = poweron_evt;
   // edge detect between the second and third stages, so a long event sets the flag once
   assign evt_pulse = sync2_q & ~sync3_q;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sync1_q    <= '0;
         sync2_q    <= '0;
         sync3_q    <= '0;
         sleep_s1_q <= 1'b0;
         sleep_s2_q <= 1'b0;
      end else begin
         sync1_q    <= evt_raw;
         sync2_q    <= sync1_q;
         sync3_q    <= sync2_q;
         sleep_s1_q <= sleep_active;
         sleep_s2_q <= sleep_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb decode
   logic access_phase;
   logic wr_en;
   logic sel_cause;
   logic sel_power;
   logic wr_cause;
   logic wr_power;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction

   assign access_phase = psel & penable;
   assign wr_en        = access_phase & pwrite & pready;
   assign sel_cause    = hit(paddr, RESET_CAUSE_STATUS_OFS);
   assign sel_power    = hit(paddr, POWER_CONTROL_OFS);
   assign wr_cause     = wr_en & sel_cause;
   assign wr_power     = wr_en & sel_power;

   ////////////////////////////////////////////////////////////////////////
   // sticky cause flags: a write stores 0 to clear; an event in the same
   // cycle wins so it is never lost
   logic [CAUSE_WIDTH-1:0] cause_q;
   logic [CAUSE_WIDTH-1:0] cause_d;
   logic [CAUSE_WIDTH-1:0] cause_keep;

   assign cause_keep = wr_cause ? (cause_q & pwdata[CAUSE_WIDTH-1:0]) : cause_q; // [RULE6]
   assign cause_d    = cause_keep | evt_pulse; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]

   // power-on is assumed at sys_rst, so the power-up flag resets to 1
   always_ff @(posedge core_clk) begin
      if (sys_rst) cause_q <= CAUSE_RESET;
      else         cause_q <= cause_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // power control
   logic keep_q;
   logic keep_d;
   logic standby_d;

   assign keep_d    = wr_power ? pwdata[KEEPALIVE_BIT] : keep_q;
   assign standby_d = sleep_s2_q & ~keep_d; // [RULE7]

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         keep_q                     <= KEEPALIVE_RESET;
         regulator_keepalive_select <= KEEPALIVE_RESET;
         regulator_standby          <= 1'b0;
      end else begin
         keep_q                     <= keep_d;
         regulator_keepalive_select <= keep_d;
         regulator_standby          <= standby_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb response: one wait state, pready registered
   logic [31:0] rdata_d;
   logic        err_d;
   logic        resp_start;
   logic [31:0] prdata_d;

   assign rdata_d = sel_cause ? {{(32-CAUSE_WIDTH){1'b0}}, cause_q}
                  : sel_power ? {31'h0000_0000, keep_q} // [RULE8]
                  : UNMAPPED_RDATA;
   assign err_d   = ~(sel_cause | sel_power);
   // fires once per access phase, so pready can never stick high
   assign resp_start = access_phase & ~pready;
   assign prdata_d   = (resp_start & ~pwrite) ? rdata_d : 32'h0000_0000;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= resp_start;
         prdata  <= prdata_d;
         pslverr <= resp_start & err_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // assertions
   property p_watchdog_set;
      @(posedge core_clk) disable iff (sys_rst)
         evt_pulse[WATCHDOG_BIT] |=> cause_q[WATCHDOG_BIT];
   endproperty
   a_watchdog_set: assert property (p_watchdog_set) // [RULE1]
      else $error("watchdog flag not set");

   property p_sleep_set;
      @(posedge core_clk) disable iff (sys_rst)
         $rose(sync2_q[WAKE_SLEEP_BIT]) |=> cause_q[WAKE_SLEEP_BIT];
   endproperty
   a_sleep_set: assert property (p_sleep_set) // [RULE2]
      else $error("sleep wake flag not set");

   property p_idle_set;
      @(posedge core_clk) disable iff (sys_rst)
         evt_pulse[WAKE_IDLE_BIT] ##1 1'b1 |-> cause_q[WAKE_IDLE_BIT];
   endproperty
   a_idle_set: assert property (p_idle_set) // [RULE3]
      else $error("idle wake flag not set");

   property p_brownout_set;
      @(posedge core_clk) disable iff (sys_rst)
         evt_pulse[UNDERVOLTAGE_BIT] |=> $past(evt_pulse[UNDERVOLTAGE_BIT])
                                         && cause_q[UNDERVOLTAGE_BIT];
   endproperty
   a_brownout_set: assert property (p_brownout_set) // [RULE4]
      else $error("brownout flag not set");

   property p_poweron_set;
      @(posedge core_clk) disable iff (sys_rst)
         evt_pulse[POWERUP_BIT] && wr_cause |=> cause_q[POWERUP_BIT];
   endproperty
   a_poweron_set: assert property (p_poweron_set) // [RULE5]
      else $error("power flag lost on clear");

   property p_sticky_hold;
      @(posedge core_clk) disable iff (sys_rst)
         cause_q[UNDERVOLTAGE_BIT] && !wr_cause |=> cause_q[UNDERVOLTAGE_BIT];
   endproperty
   a_sticky_hold: assert property (p_sticky_hold) // [RULE6]
      else $error("flag dropped without clear");

   property p_no_spurious;
      @(posedge core_clk) disable iff (sys_rst)
         !cause_q[POWERUP_BIT] && !evt_pulse[POWERUP_BIT] |=> !cause_q[POWERUP_BIT];
   endproperty
   a_no_spurious: assert property (p_no_spurious) // [RULE6]
      else $error("flag set without event");

   property p_regulator;
      @(posedge core_clk) disable iff (sys_rst)
         sleep_s2_q && keep_q && !wr_power |=> !regulator_standby;
   endproperty
   a_regulator: assert property (p_regulator) // [RULE7]
      else $error("regulator in standby with keepalive");

   property p_standby;
      @(posedge core_clk) disable iff (sys_rst)
         sleep_s2_q && !regulator_keepalive_select && !wr_power |=> regulator_standby;
   endproperty
   a_standby: assert property (p_standby) // [RULE7]
      else $error("regulator not in standby");

   property p_power_upper_zero;
      @(posedge core_clk) disable iff (sys_rst)
         pready && !pwrite && $past(sel_power) && $past(access_phase) |-> prdata[31:1] == 31'h0;
   endproperty
   a_power_upper_zero: assert property (p_power_upper_zero) // [RULE8]
      else $error("upper bits nonzero");

   ////////////////////////////////////////////////////////////////////////
   // clear, hold and bus response checks
   property p_watchdog_clear;
      @(posedge core_clk) disable iff (sys_rst)
         wr_cause && !pwdata[WATCHDOG_BIT] && !evt_pulse[WATCHDOG_BIT]
            |=> !cause_q[WATCHDOG_BIT];
   endproperty
   a_watchdog_clear: assert property (p_watchdog_clear) // [RULE1]
      else $error("watchdog flag not cleared");

   property p_sleep_clear;
      @(posedge core_clk) disable iff (sys_rst)
         wr_cause && !pwdata[WAKE_SLEEP_BIT] && !evt_pulse[WAKE_SLEEP_BIT]
            |=> !cause_q[WAKE_SLEEP_BIT];
   endproperty
   a_sleep_clear: assert property (p_sleep_clear) // [RULE2]
      else $error("sleep wake flag not cleared");

   property p_idle_clear;
      @(posedge core_clk) disable iff (sys_rst)
         wr_cause && !pwdata[WAKE_IDLE_BIT] && !evt_pulse[WAKE_IDLE_BIT]
            |=> !cause_q[WAKE_IDLE_BIT];
   endproperty
   a_idle_clear: assert property (p_idle_clear) // [RULE3]
      else $error("idle wake flag not cleared");

   property p_brownout_clear;
      @(posedge core_clk) disable iff (sys_rst)
         wr_cause && !pwdata[UNDERVOLTAGE_BIT] && !evt_pulse[UNDERVOLTAGE_BIT]
            |=> !cause_q[UNDERVOLTAGE_BIT];
   endproperty
   a_brownout_clear: assert property (p_brownout_clear) // [RULE4]
      else $error("brownout flag not cleared");

   property p_poweron_clear;
      @(posedge core_clk) disable iff (sys_rst)
         wr_cause && !pwdata[POWERUP_BIT] && !evt_pulse[POWERUP_BIT]
            |=> !cause_q[POWERUP_BIT];
   endproperty
   a_poweron_clear: assert property (p_poweron_clear) // [RULE5]
      else $error("power flag not cleared");

   property p_keep_write;
      @(posedge core_clk) disable iff (sys_rst)
         wr_power |=> keep_q == $past(pwdata[KEEPALIVE_BIT])
                      && regulator_keepalive_select == $past(pwdata[KEEPALIVE_BIT]);
   endproperty
   a_keep_write: assert property (p_keep_write) // [RULE7]
      else $error("keepalive write not taken");

   property p_awake_active;
      @(posedge core_clk) disable iff (sys_rst)
         !sleep_s2_q |=> !regulator_standby;
   endproperty
   a_awake_active: assert property (p_awake_active) // [RULE7]
      else $error("regulator in standby while awake");

   property p_flags_hold;
      @(posedge core_clk) disable iff (sys_rst)
         !wr_cause |=> (cause_q & $past(cause_q)) == $past(cause_q);
   endproperty
   a_flags_hold: assert property (p_flags_hold) // [RULE6]
      else $error("cause flag dropped without write");

   property p_no_set_without_event;
      @(posedge core_clk) disable iff (sys_rst)
         (cause_q & ~$past(cause_q) & ~$past(evt_pulse)) == '0;
   endproperty
   a_no_set_without_event: assert property (p_no_set_without_event) // [RULE4]
      else $error("cause flag set without event");

   property p_unmapped_no_write;
      @(posedge core_clk) disable iff (sys_rst)
         wr_en && !sel_cause && !sel_power
            |=> keep_q == $past(keep_q) && cause_q == ($past(cause_q) | $past(evt_pulse));
   endproperty
   a_unmapped_no_write: assert property (p_unmapped_no_write) // [RULE6]
      else $error("unmapped write changed a register");

   property p_pready_one;
      @(posedge core_clk) disable iff (sys_rst)
         pready |=> !pready;
   endproperty
   a_pready_one: assert property (p_pready_one)
      else $error("pready longer than one cycle");

   property p_ready_after_access;
      @(posedge core_clk) disable iff (sys_rst)
         access_phase && !pready |=> pready;
   endproperty
   a_ready_after_access: assert property (p_ready_after_access)
      else $error("pready late after access phase");

   property p_cause_upper_zero;
      @(posedge core_clk) disable iff (sys_rst)
         pready && !pwrite && $past(sel_cause) && $past(access_phase)
            |-> prdata[31:CAUSE_WIDTH] == '0;
   endproperty
   a_cause_upper_zero: assert property (p_cause_upper_zero)
      else $error("cause upper bits nonzero");

endmodule

// ===== design/rst_cause_pkg.sv
package rst_cause_pkg;
   // register byte offsets on the bus
   localparam logic [11:0] RESET_CAUSE_STATUS_OFS = 12'h000;
   localparam logic [11:0] POWER_CONTROL_OFS      = 12'h004;
   // reset cause field positions
   localparam int POWERUP_BIT      = 0;
   localparam int UNDERVOLTAGE_BIT = 1;
   localparam int WAKE_IDLE_BIT    = 2;
   localparam int WAKE_SLEEP_BIT   = 3;
   localparam int WATCHDOG_BIT     = 4;
   localparam int CAUSE_WIDTH      = 5;
   // power control field position
   localparam int KEEPALIVE_BIT    = 0;
   // reset values
   localparam logic [4:0]  CAUSE_RESET     = 5'h01;
   localparam logic        KEEPALIVE_RESET = 1'b0;
   localparam logic [31:0] UNMAPPED_RDATA  = 32'h0000_0000;
endpackage

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import rst_cause_pkg::*;
   logic        core_clk;
   logic        sys_rst;
   logic [4:0]  evt;
   logic        sleep_active;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        regulator_standby;
   logic        regulator_keepalive_select;
   logic        er;
   int          failures;
   int          checks_done;

   reset_cause_and_sleep_power_status reset_cause_and_sleep_power_status_i (
      .core_clk(core_clk), .sys_rst(sys_rst),
      .watchdog_expiry_evt(evt[WATCHDOG_BIT]), .sleep_exit_evt(evt[WAKE_SLEEP_BIT]),
      .idle_exit_evt(evt[WAKE_IDLE_BIT]), .brownout_evt(evt[UNDERVOLTAGE_BIT]),
      .poweron_evt(evt[POWERUP_BIT]), .sleep_active(sleep_active),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .regulator_standby(regulator_standby),
      .regulator_keepalive_select(regulator_keepalive_select));

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic conclude;
      if (failures == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // request held until pready is sampled high; no fixed latency assumed
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge core_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge core_clk);
      end while (pready !== 1'b1);
      r = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      chk(r, exp);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      evt = 5'h00;
      sleep_active = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      failures = 0;
      checks_done = 0;
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'b0;
      rdchk(RESET_CAUSE_STATUS_OFS, {27'h0, CAUSE_RESET});
      chk({31'h0, er}, 32'h0);
      rdchk(POWER_CONTROL_OFS, 32'h0);
      wr(RESET_CAUSE_STATUS_OFS, 32'h0);
      rdchk(RESET_CAUSE_STATUS_OFS, 32'h0);
      for (int i = 0; i < CAUSE_WIDTH; i++) begin
         @(posedge core_clk) evt[i] <= 1'b1;
         repeat (3) @(posedge core_clk);
         evt[i] <= 1'b0;
         repeat (4) @(posedge core_clk);
         rdchk(RESET_CAUSE_STATUS_OFS, 32'h1 << i);
         // writing one keeps the flag, so it must survive a second read
         wr(RESET_CAUSE_STATUS_OFS, 32'h1 << i);
         rdchk(RESET_CAUSE_STATUS_OFS, 32'h1 << i);
         wr(RESET_CAUSE_STATUS_OFS, 32'h0);
         rdchk(RESET_CAUSE_STATUS_OFS, 32'h0);
      end
      // the event edge lands on the very edge the clear is taken; the event must win
      fork
         wr(RESET_CAUSE_STATUS_OFS, 32'h0);
         begin
            @(posedge core_clk) evt[POWERUP_BIT] <= 1'b1;
            repeat (3) @(posedge core_clk);
            evt[POWERUP_BIT] <= 1'b0;
         end
      join
      repeat (4) @(posedge core_clk);
      rdchk(RESET_CAUSE_STATUS_OFS, 32'h1 << POWERUP_BIT);
      wr(RESET_CAUSE_STATUS_OFS, 32'h0);
      rdchk(RESET_CAUSE_STATUS_OFS, 32'h0);
      wr(POWER_CONTROL_OFS, 32'hFFFF_FFFF);
      rdchk(POWER_CONTROL_OFS, 32'h0000_0001);
      chk({31'h0, er}, 32'h0);
      chk({31'h0, regulator_keepalive_select}, 32'h1);
      @(posedge core_clk) sleep_active <= 1'b1;
      repeat (5) @(posedge core_clk);
      chk({31'h0, regulator_standby}, 32'h0);
      wr(POWER_CONTROL_OFS, 32'hFFFF_FFFE);
      repeat (5) @(posedge core_clk);
      chk({31'h0, regulator_standby}, 32'h1);
      chk({31'h0, regulator_keepalive_select}, 32'h0);
      @(posedge core_clk) sleep_active <= 1'b0;
      repeat (5) @(posedge core_clk);
      chk({31'h0, regulator_standby}, 32'h0);
      // unmapped word answers with zero data and an error, and a write there lands nowhere
      rdchk(12'h008, 32'h0);
      chk({31'h0, er}, 32'h1);
      wr(12'h008, 32'hFFFF_FFFF);
      chk({31'h0, er}, 32'h1);
      rdchk(POWER_CONTROL_OFS, 32'h0);
      // a second reset brings back the power-up flag and drops the keep-alive choice
      wr(POWER_CONTROL_OFS, 32'h1);
      rdchk(POWER_CONTROL_OFS, 32'h1);
      @(posedge core_clk) sys_rst <= 1'b1;
      repeat (4) @(posedge core_clk);
      sys_rst <= 1'b0;
      rdchk(RESET_CAUSE_STATUS_OFS, {27'h0, CAUSE_RESET});
      rdchk(POWER_CONTROL_OFS, {31'h0, KEEPALIVE_RESET});
      chk({31'h0, regulator_keepalive_select}, {31'h0, KEEPALIVE_RESET});
      conclude();
   end

   initial begin
      #50000;
      failures++;
      conclude();
   end
endmodule
